// *** design/adcpts_pkg.sv ***
/*
  Shared constants of the converter power and trim sequencer: control word
  layout, host command map, and every timing figure with its cycle count.
  Assumes a 100 MHz ref_clk on both ends and a nominal 6 MHz master clock.
*/
package adcpts_pkg;

  // Clock rates
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MCLK_NOM_KHZ  = 6000;

  // Calibration lengths as printed, then in master clock cycles
  localparam int unsigned CAL_FULL_US   = 41700;
  localparam int unsigned CAL_PAIR_US   = 9260;
  localparam int unsigned CAL_ONE_US    = 4630;
  localparam int unsigned CAL_FULL_MCLK = CAL_FULL_US * MCLK_NOM_KHZ / 1000;
  localparam int unsigned CAL_PAIR_MCLK = CAL_PAIR_US * MCLK_NOM_KHZ / 1000;
  localparam int unsigned CAL_ONE_MCLK  = CAL_ONE_US * MCLK_NOM_KHZ / 1000;

  // Conversion length in master clock cycles
  localparam int unsigned CONV_NS   = 3500;
  localparam int unsigned CONV_MCLK = CONV_NS * MCLK_NOM_KHZ / 1000000;

  // Wake time and trigger low time, least times rounded up
  localparam int unsigned WAKE_NS      = 5000;
  localparam int unsigned WAKE_CYC     = (WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_LOW_NS  = 5000;
  localparam int unsigned TRIG_LOW_CYC = (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Host idle times after supplies come up
  localparam int unsigned POR_IDLE_MS  = 42;
  localparam int unsigned POR_IDLE_CYC = POR_IDLE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned INIT_PWR_US  = 300;
  localparam int unsigned INIT_PWR_CYC = INIT_PWR_US * 1000 / CLK_PERIOD_NS;

  // Small counts
  localparam int unsigned STRAP_CYC      = 3;
  localparam int unsigned STRAP_HOLD_CYC = 16;
  localparam int unsigned GUARD_CYC      = 8;
  localparam int unsigned CNT_W          = 18;

  // Control word layout
  localparam int unsigned CTRL_W      = 8;
  localparam int unsigned BIT_MODE_LO = 0;
  localparam int unsigned BIT_MODE_HI = 1;
  localparam int unsigned BIT_TRIM    = 2;
  localparam int unsigned BIT_VAR_LO  = 3;
  localparam int unsigned BIT_SYS     = 5;
  localparam int unsigned BIT_CONV    = 6;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] VAR_FULL = 2'h0;
  localparam logic [1:0] VAR_PAIR = 2'h1;

  // Synchronised link bits: trigger, trim, doze, master clock, strobe, data
  localparam int unsigned SYNC_W = 5 + CTRL_W;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 13'h0007;

  // Host command map and bit positions
  localparam int unsigned ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_CTRL  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_PINS  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_PULSE = 4'h8;
  localparam logic [ADDR_W-1:0] REG_STAT  = 4'hC;
  localparam int unsigned PULSE_TRIG = 0;
  localparam int unsigned PULSE_TRIM = 1;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_READY = 1;
  localparam int unsigned STAT_REFUSED = 2;

endpackage : adcpts_pkg

// *** design/adcpts_link_if.sv ***
/*
  Pins between the host and the converter's sequencer.
  Assumes both ends run on the same ref_clk; the device resynchronises pins.
*/
`timescale 1ns/1ps
`default_nettype none
interface adcpts_link_if;
  logic       sampleTriggerN;
  logic       trimRequestN;
  logic       dozeN;
  logic       masterClockIn;
  logic       ctrlWrite;
  logic [7:0] ctrlData;
  logic       busy;

  modport device (input sampleTriggerN, trimRequestN, dozeN, masterClockIn, ctrlWrite, ctrlData, output busy);
  modport host   (output sampleTriggerN, trimRequestN, dozeN, masterClockIn, ctrlWrite, ctrlData, input busy);
endinterface : adcpts_link_if
`default_nettype wire

// *** design/adcpts_sync.sv ***
/*
  Two flip-flop synchroniser, one pair per bit.
  Assumes the inputs change no faster than the clock can follow.
*/
`timescale 1ns/1ps
`default_nettype none
module adcpts_sync #(
  parameter int unsigned   W         = 1,
  parameter logic [W-1:0]  RESET_VAL = '0
) (
  input  wire logic         ref_clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta;
    logic hold;
    // First stage feeds only the second
    always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
        meta <= RESET_VAL[i];
        hold <= RESET_VAL[i];
      end else begin
        meta <= d[i];
        hold <= meta;
      end
    end
    assign q[i] = hold;
  end
endmodule : adcpts_sync
`default_nettype wire

// *** design/adcpts_device.sv ***
/*
  Converter end: power state and calibration sequencer with its control
  word register, counting calibration and conversion in master clock edges.
  Assumes the host keeps ctrlData stable from its write strobe onward and
  that master_clock_in is far slower than ref_clk.
*/
// The strobed register port and the placing of the registers were chosen for this implementation.
// Notes on behaviour
// RULE1: Power-on calibration ignores doze pin low.
// RULE2: Trim pin high at power-on skips calibration.
// RULE3: Host idles about 42 ms after power-on.
// RULE4: Without autocalibration host waits 300 us.
// RULE5: Ready 5 us after leaving full power-down.
// RULE6: Between-conversion modes power down when busy falls.
// RULE7: Trigger falling edge wakes, ready after 5 us.
// RULE8: Trigger rising edge starts conversion; hold low 5us.
// RULE9: Software conversion needs a preceding power-up write.
// RULE10: After calibration stay powered until commanded down.
// RULE11: Partial power-down calibration takes three writes.
// RULE12: Self and system calibration, several variants each.
// RULE13: Calibration starts by trim pulse or launch bit.
// RULE14: Full 41.7, pair 9.26, single 4.63 ms.
// RULE15: Calibration lengths count master clock cycles.
// RULE16: Conversion lasts 3.5 us at 6 MHz.
// RULE17: Host recalibrates only when conditions change.
// RULE18: On-chip reference: skip autocal, wait 150 ms. The host skips autocal but waits only InitPwrCycles (300 us).
// RULE19: Power state decoded from mode bits and doze.
// RULE20: Busy rises at launch, falls when calibration ends.
// RULE21: Host issues nothing new while busy. Doze pin writes are still taken while busy.
`timescale 1ns/1ps
`default_nettype none
module adcpts_device
  import adcpts_pkg::*;
#(
  parameter int unsigned CalFullCycles = CAL_FULL_MCLK,
  parameter int unsigned CalPairCycles = CAL_PAIR_MCLK,
  parameter int unsigned CalOneCycles  = CAL_ONE_MCLK
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  adcpts_link_if.device   link,
  output logic            poweredUp,
  output logic            partialDown,
  output logic [2:0]      calKind,
  output logic            calDone,
  output logic            convDone
);

  typedef enum logic [6:0] {
    ST_STRAP = 7'h01,
    ST_POR   = 7'h02,
    ST_UP    = 7'h04,
    ST_CAL   = 7'h08,
    ST_CONV  = 7'h10,
    ST_DOWN  = 7'h20,
    ST_WAKE  = 7'h40
  } adcpts_state_e;

  adcpts_state_e     state;
  adcpts_state_e     next_state;
  logic [CNT_W-1:0]  cnt;
  logic [CNT_W-1:0]  next_cnt;
  logic [CTRL_W-1:0] ctrlReg;
  logic              busy;
  logic [SYNC_W-1:0] pinS;
  logic              trigS, trimS, dozeS, mclkS, wrS;
  logic [CTRL_W-1:0] dataS;
  logic              trigPrev, trimPrev, dozePrev, mclkPrev;
  logic              trigRise, trigFall, trimRise, trimFall, dozeRise, mclkRise;
  logic              swCal, swConv, calStart, convStart, downReq, wakeReq;
  logic              calEnd, convEnd, betweenConv, mode00;
  logic [2:0]        kindLoad;
  logic [CNT_W-1:0]  calLoad;

  // Stay up: 01, or 00 with the doze pin high
  function automatic logic stayUp(input logic [CTRL_W-1:0] w, input logic doze);
    stayUp = !w[BIT_MODE_HI] && (w[BIT_MODE_LO] || doze);
  endfunction : stayUp

  // Power down after each conversion: 00 with doze low, or 11
  function automatic logic downAfterConv(input logic [CTRL_W-1:0] w, input logic doze);
    downAfterConv = (w[BIT_MODE_HI] && w[BIT_MODE_LO]) || (!w[BIT_MODE_HI] && !w[BIT_MODE_LO] && !doze);
  endfunction : downAfterConv

  // Every pin crosses two flip-flops before any logic looks at it
  adcpts_sync #(
    .W         (SYNC_W),
    .RESET_VAL (SYNC_RESET)
  ) u_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .d       ({link.ctrlData, link.ctrlWrite, link.masterClockIn, link.dozeN,
               link.trimRequestN, link.sampleTriggerN}),
    .q       (pinS)
  );

  assign trigS = pinS[0];
  assign trimS = pinS[1];
  assign dozeS = pinS[2];
  assign mclkS = pinS[3];
  assign wrS   = pinS[4];
  assign dataS = pinS[SYNC_W-1:5];

  // Previous levels for edge detection on synchronised pins
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trigPrev <= 1'b1;
      trimPrev <= 1'b1;
      dozePrev <= 1'b1;
      mclkPrev <= 1'b0;
    end else begin
      trigPrev <= trigS;
      trimPrev <= trimS;
      dozePrev <= dozeS;
      mclkPrev <= mclkS;
    end
  end

  assign trigRise = trigS && !trigPrev;
  assign trigFall = !trigS && trigPrev;
  assign trimRise = trimS && !trimPrev;
  assign trimFall = !trimS && trimPrev;
  assign dozeRise = dozeS && !dozePrev;
  assign mclkRise = mclkS && !mclkPrev;

  // Power mode decode from the stored control word and doze pin
  assign betweenConv = downAfterConv(ctrlReg, dozeS); // RULE19
  assign mode00      = !ctrlReg[BIT_MODE_HI] && !ctrlReg[BIT_MODE_LO]; // RULE19

  // Launch events; calibration wins over conversion on a shared cycle
  assign swCal     = wrS && dataS[BIT_TRIM];
  assign swConv    = wrS && dataS[BIT_CONV];
  assign calStart  = ((state == ST_UP) && (trimRise || swCal)) || ((state == ST_POR) && trimRise); // RULE13
  assign convStart = (state == ST_UP) && !calStart && (trigRise || swConv); // RULE8
  assign downReq   = (state == ST_UP) && !calStart && !convStart && wrS && dataS[BIT_MODE_HI]; // RULE19
  assign calEnd    = (state == ST_CAL) && mclkRise && (cnt == CNT_W'(1));
  assign convEnd   = (state == ST_CONV) && mclkRise && (cnt == CNT_W'(1));

  // Wake sources: trigger fall in a between-conversion mode, a power-up
  // write, doze rising in mode 00, or a trim pulse whose width covers wake
  assign wakeReq = (state == ST_DOWN) && ((trigFall && betweenConv) // RULE7
                   || (wrS && stayUp(dataS, dozeS)) // RULE5
                   || (dozeRise && mode00) || trimFall);

  // Calibration family and variant: a write supplies its own, a pin pulse
  // uses the stored word, power-on is always a full self calibration
  always_comb begin
    kindLoad = {ctrlReg[BIT_SYS], ctrlReg[BIT_VAR_LO+1], ctrlReg[BIT_VAR_LO]}; // RULE12
    if (state == ST_POR) begin
      kindLoad = {1'b0, VAR_FULL};
    end else if (swCal) begin
      kindLoad = {dataS[BIT_SYS], dataS[BIT_VAR_LO+1], dataS[BIT_VAR_LO]};
    end
    // Self and system variants share lengths
    case (kindLoad[1:0])
      VAR_FULL: calLoad = CNT_W'(CalFullCycles); // RULE14
      VAR_PAIR: calLoad = CNT_W'(CalPairCycles); // RULE14
      default:  calLoad = CNT_W'(CalOneCycles); // RULE14
    endcase
  end

  // Sequencer next state; CAL and CONV advance only on master clock edges
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      ST_STRAP: begin
        if (cnt == CNT_W'(1)) begin
          next_state = trimS ? ST_UP : ST_POR; // RULE2
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      ST_POR: begin
        // Doze pin is not looked at until power-on calibration is over
        if (calStart) begin // RULE1
          next_state = ST_CAL;
          next_cnt   = calLoad;
        end
      end
      ST_UP: begin
        if (calStart) begin
          next_state = ST_CAL;
          next_cnt   = calLoad;
        end else if (convStart) begin
          next_state = ST_CONV;
          next_cnt   = CNT_W'(CONV_MCLK); // RULE16
        end else if (downReq) begin
          next_state = ST_DOWN;
        end
      end
      ST_CAL: begin
        if (calEnd) begin
          next_state = ST_UP; // RULE10
        end else if (mclkRise) begin
          next_cnt = cnt - CNT_W'(1); // RULE15
        end
      end
      ST_CONV: begin
        if (convEnd) begin
          next_state = betweenConv ? ST_DOWN : ST_UP; // RULE6
        end else if (mclkRise) begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      ST_DOWN: begin
        if (wakeReq) begin
          next_state = ST_WAKE;
          next_cnt   = CNT_W'(WAKE_CYC - 1); // RULE5 RULE7: sync lag adds the last cycle
        end
      end
      ST_WAKE: begin
        if (cnt == CNT_W'(1)) begin
          next_state = ST_UP; // RULE7
        end else begin
          next_cnt = cnt - CNT_W'(1);
        end
      end
      default: begin
        next_state = ST_STRAP;
        next_cnt   = CNT_W'(STRAP_CYC);
      end
    endcase
  end

  // Sequencer state; the strap wait lets the trim pin settle through the sync
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_STRAP;
      cnt   <= CNT_W'(STRAP_CYC);
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Control word holds the last write, including the mode bits
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlReg <= CTRL_RESET;
    end else if (wrS) begin
      ctrlReg <= dataS;
    end
  end

  // Busy covers calibration and conversion, from launch to end
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
    end else begin
      busy <= (next_state == ST_CAL) || (next_state == ST_CONV); // RULE20
    end
  end
  assign link.busy = busy;

  // Power status and completion pulses for the local user
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      poweredUp   <= 1'b0;
      partialDown <= 1'b0;
      calKind     <= 3'h0;
      calDone     <= 1'b0;
      convDone    <= 1'b0;
    end else begin
      poweredUp   <= (next_state == ST_UP) || (next_state == ST_CAL) || (next_state == ST_CONV);
      partialDown <= (next_state == ST_DOWN) && (wrS ? (dataS[BIT_MODE_HI] && dataS[BIT_MODE_LO])
                                                     : (ctrlReg[BIT_MODE_HI] && ctrlReg[BIT_MODE_LO]));
      calDone     <= calEnd;
      convDone    <= convEnd;
      if (calStart) begin
        calKind <= kindLoad;
      end
    end
  end

endmodule : adcpts_device
`default_nettype wire

// *** design/adcpts_host.sv ***
/*
  Host end: drives trigger, trim, doze, master clock and control writes,
  and refuses commands that would break the device's sequencing.
  Assumes software on the command port reads data one cycle after a read.
*/
`timescale 1ns/1ps
`default_nettype none
module adcpts_host
  import adcpts_pkg::*;
#(
  parameter int unsigned PorIdleCycles = POR_IDLE_CYC,
  parameter int unsigned InitPwrCycles = INIT_PWR_CYC,
  parameter int unsigned MclkHalf      = 8,
  parameter bit          SkipAutoCal   = 1'b0
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  adcpts_link_if.host            link,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  wire logic [CTRL_W-1:0] cmdWdata,
  input  wire logic              cmdWrite,
  input  wire logic              cmdRead,
  output logic      [CTRL_W-1:0] cmdRdata
);

  localparam int unsigned StartupCycles = SkipAutoCal ? InitPwrCycles : PorIdleCycles;

  logic [7:0]        divCnt;
  logic              mclk;
  logic [31:0]       startCnt;
  logic              ready;
  logic [15:0]       pulseCnt;
  logic              pulseTrig, pulseTrim;
  logic              trigOut, trimOut, dozeOut;
  logic [CTRL_W-1:0] ctrlOut;
  logic              wrOut;
  logic              busyS;
  logic              pwrUpLast, needPwrUp, refused;
  logic              cmdOk, ctrlGo, ctrlBad, pulseGo, pulseBad;

  adcpts_sync #(
    .W         (1),
    .RESET_VAL (1'b0)
  ) u_busy_sync (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .d       (link.busy),
    .q       (busyS)
  );

  // Control and pulse commands wait for start-up, a quiet busy line and the guard window,
  // which covers the pin round trip before busy can be seen
  assign cmdOk    = ready && !busyS && (pulseCnt == 16'h0000); // RULE21
  assign ctrlGo   = cmdWrite && (cmdAddr == REG_CTRL) && cmdOk
                    && !(cmdWdata[BIT_CONV] && !pwrUpLast) // RULE9
                    && !(cmdWdata[BIT_TRIM] && needPwrUp); // RULE11
  assign ctrlBad  = cmdWrite && (cmdAddr == REG_CTRL) && !ctrlGo;
  assign pulseGo  = cmdWrite && (cmdAddr == REG_PULSE) && cmdOk;
  assign pulseBad = cmdWrite && (cmdAddr == REG_PULSE) && !cmdOk;

  // Master clock divided down from ref_clk
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt <= 8'h00;
      mclk   <= 1'b0;
    end else if (divCnt == 8'(MclkHalf - 1)) begin
      divCnt <= 8'h00;
      mclk   <= ~mclk;
    end else begin
      divCnt <= divCnt + 8'h01;
    end
  end

  // Idle time after supplies come up before control and pulse commands are taken
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      startCnt <= 32'h0000_0000;
      ready    <= 1'b0;
    end else if (!ready) begin
      startCnt <= startCnt + 32'h0000_0001;
      ready    <= (startCnt == StartupCycles - 1); // RULE3 RULE4
    end
  end

  // Pin pulses: trigger or trim low for the wake time, then a guard
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulseCnt  <= 16'h0000;
      pulseTrig <= 1'b0;
      pulseTrim <= 1'b0;
    end else if (pulseGo) begin
      pulseCnt  <= 16'(TRIG_LOW_CYC + GUARD_CYC);
      pulseTrig <= cmdWdata[PULSE_TRIG];
      pulseTrim <= cmdWdata[PULSE_TRIM];
    end else if (ctrlGo) begin
      pulseCnt  <= 16'(GUARD_CYC);
      pulseTrig <= 1'b0;
      pulseTrim <= 1'b0;
    end else if (pulseCnt != 16'h0000) begin
      pulseCnt <= pulseCnt - 16'h0001;
    end
  end

  // Pin drivers; trim is held low after reset as a strap unless skipped
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      trigOut <= 1'b1;
      trimOut <= SkipAutoCal; // RULE18
      dozeOut <= 1'b1;
    end else begin
      trigOut <= !(pulseTrig && (pulseCnt > 16'(GUARD_CYC))); // RULE8
      if (ready || (startCnt >= 32'(STRAP_HOLD_CYC))) begin
        trimOut <= !(pulseTrim && (pulseCnt > 16'(GUARD_CYC)));
      end
      if (cmdWrite && (cmdAddr == REG_PINS)) begin
        dozeOut <= cmdWdata[0];
      end
    end
  end

  // Control write: one-cycle strobe, data held until the next write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlOut <= CTRL_RESET;
      wrOut   <= 1'b0;
    end else begin
      wrOut <= ctrlGo;
      if (ctrlGo) begin
        ctrlOut <= cmdWdata;
      end
    end
  end

  // Sequencing memory: last write was a bare power-up, partial down pending
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pwrUpLast <= 1'b0;
      needPwrUp <= 1'b0;
    end else if (ctrlGo) begin
      pwrUpLast <= !cmdWdata[BIT_MODE_HI] && cmdWdata[BIT_MODE_LO]
                   && !cmdWdata[BIT_CONV] && !cmdWdata[BIT_TRIM]; // RULE9
      if (cmdWdata[BIT_MODE_HI] && cmdWdata[BIT_MODE_LO]) begin
        needPwrUp <= 1'b1; // RULE11
      end else if (!cmdWdata[BIT_MODE_HI]) begin
        needPwrUp <= 1'b0;
      end
    end
  end

  // Sticky refusal flag; a new refusal wins over the clearing write
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      refused <= 1'b0;
    end else if (ctrlBad || pulseBad) begin
      refused <= 1'b1;
    end else if (cmdWrite && (cmdAddr == REG_STAT) && cmdWdata[STAT_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // Read data stands in the cycle after the read strobe only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmdRdata <= 8'h00;
    end else if (cmdRead) begin
      case (cmdAddr)
        REG_CTRL:  cmdRdata <= ctrlOut;
        REG_PINS:  cmdRdata <= {7'h00, dozeOut};
        REG_STAT:  cmdRdata <= {5'h00, refused, ready, busyS};
        default:   cmdRdata <= 8'h00;
      endcase
    end else begin
      cmdRdata <= 8'h00;
    end
  end

  assign link.masterClockIn  = mclk;
  assign link.sampleTriggerN = trigOut;
  assign link.trimRequestN   = trimOut;
  assign link.dozeN          = dozeOut;
  assign link.ctrlWrite      = wrOut;
  assign link.ctrlData       = ctrlOut;

endmodule : adcpts_host
`default_nettype wire

// *** verif/adcpts_link_chk.sv ***
/*
  Link checker: watches the pins between host and device.
  Assumes one ref_clk, a master clock of 16 ref_clk cycles and the bench's
  short calibration counts.
*/
`timescale 1ns/1ps
`default_nettype none
module adcpts_link_chk #(
  parameter int unsigned CalFull = 40,
  parameter int unsigned CalPair = 20,
  parameter int unsigned CalOne  = 10
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic       sampleTriggerN,
  input wire logic       trimRequestN,
  input wire logic       dozeN,
  input wire logic       masterClockIn,
  input wire logic       ctrlWrite,
  input wire logic [7:0] ctrlData,
  input wire logic       busy
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic        trigD, trimD, mclkD, busyD;
  logic [3:0]  age;
  logic [15:0] lowCnt, mclkCnt;
  // Launch age, trigger low time, master clock rises in a busy span; age and low time saturate, the rise count can wrap
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {trigD, trimD, mclkD, busyD} <= 4'h8;
      age <= 4'hF;
      lowCnt <= 16'h0000;
      mclkCnt <= 16'h0000;
    end else begin
      {trigD, trimD, mclkD, busyD} <= {sampleTriggerN, trimRequestN, masterClockIn, busy};
      if ((sampleTriggerN & ~trigD) | (trimRequestN & ~trimD) | (ctrlWrite & (ctrlData[2] | ctrlData[6])))
        age <= 4'h0;
      else if (age != 4'hF)
        age <= age + 4'h1;
      lowCnt <= sampleTriggerN ? 16'h0000 : lowCnt + {15'h0000, lowCnt != 16'hFFFF};
      if (busy & ~busyD)
        mclkCnt <= 16'h0000;
      else if (masterClockIn & ~mclkD)
        mclkCnt <= mclkCnt + 16'h0001;
    end
  end
  sequence sLaunch; age inside {[1:7]}; endsequence
  sequence sHalf; $stable(masterClockIn) [*7] ##1 $changed(masterClockIn); endsequence
  AST_BUSY_CAUSE: assert property ($rose(busy) |-> sLaunch)
    else $error("busy rose with no launch");
  AST_BUSY_LEN: assert property ($fell(busy) |-> mclkCnt inside {[20:22], [CalFull-1:CalFull+1],
    [CalPair-1:CalPair+1], [CalOne-1:CalOne+1]}) else $error("busy span length wrong");
  AST_TRIG_WIDE: assert property ($rose(sampleTriggerN) |-> lowCnt >= 500)
    else $error("trigger low too short");
  AST_WR_PULSE: assert property (ctrlWrite |=> !ctrlWrite)
    else $error("write strobe too long");
  AST_WR_IDLE: assert property (ctrlWrite |-> !$past(busy, 3))
    else $error("write while busy");
  AST_PIN_IDLE: assert property (($fell(sampleTriggerN) || $fell(trimRequestN)) |-> !busy)
    else $error("pin pulse while busy");
  AST_MCLK_HALF: assert property ($changed(masterClockIn) |=> sHalf)
    else $error("master clock half period wrong");
  AST_DATA_HOLD: assert property ($changed(ctrlData) |-> ctrlWrite)
    else $error("control word moved without strobe");
endmodule : adcpts_link_chk
`default_nettype wire

// *** verif/testbench.sv ***
/*
  Bench: host and device joined by the link, driven from the command port.
  Assumes short calibration counts 40/20/10 and a 16-cycle master clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import adcpts_pkg::*;
  logic              ref_clk  = 1'b0;
  logic              reset_n  = 1'b0;
  logic [ADDR_W-1:0] cmdAddr  = 4'h0;
  logic [CTRL_W-1:0] cmdWdata = 8'h00;
  logic              cmdWrite = 1'b0;
  logic              cmdRead  = 1'b0;
  logic [CTRL_W-1:0] cmdRdata, stat;
  logic              poweredUp, partialDown, calDone, convDone;
  logic [2:0]        calKind;
  int                fails = 0;
  int                cmpCount = 0;
  int                n;
  localparam logic [7:0] ROW_D [8] = '{8'h05, 8'h0D, 8'h15, 8'h1D, 8'h25, 8'h2D, 8'h35, 8'h3D};
  localparam int         ROW_N [8] = '{40, 20, 10, 10, 40, 20, 10, 10};
  adcpts_link_if link ();
  adcpts_device #(.CalFullCycles(40), .CalPairCycles(20), .CalOneCycles(10)) i_adcpts_device (
    .ref_clk(ref_clk), .reset_n(reset_n), .link(link), .poweredUp(poweredUp), .partialDown(partialDown),
    .calKind(calKind), .calDone(calDone), .convDone(convDone));
  adcpts_host #(.PorIdleCycles(1000), .InitPwrCycles(64)) i_adcpts_host (
    .ref_clk(ref_clk), .reset_n(reset_n), .link(link), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdRdata(cmdRdata));
  adcpts_link_chk i_adcpts_link_chk (.ref_clk(ref_clk), .reset_n(reset_n),
    .sampleTriggerN(link.sampleTriggerN), .trimRequestN(link.trimRequestN), .dozeN(link.dozeN),
    .masterClockIn(link.masterClockIn), .ctrlWrite(link.ctrlWrite), .ctrlData(link.ctrlData), .busy(link.busy));
  // Free-running 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Idle first so the host's guard and busy sync have cleared
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    repeat (12) @(posedge ref_clk);
    cmdAddr <= a;
    cmdWdata <= d;
    cmdWrite <= 1'b1;
    @(posedge ref_clk);
    cmdWrite <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge ref_clk);
    cmdAddr <= a;
    cmdRead <= 1'b1;
    @(posedge ref_clk);
    cmdRead <= 1'b0;
    #1 stat = cmdRdata;
  endtask : rd
  // Bounded wait for a done pulse; cycles counted into cyc
  task automatic wait_pulse(input bit conv, input int lim, output int cyc);
    cyc = 0;
    do begin
      @(posedge ref_clk);
      #1 cyc++;
    end while (!(conv ? convDone : calDone) && cyc < lim);
    chk(cyc < lim, 1'b1);
  endtask : wait_pulse
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Watchdog: the whole run needs well under a quarter of this
  initial begin
    #500000;
    fails++;
    test_done();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    // Power-on full calibration, then up with kind zero
    wait_pulse(1'b0, 2000, n);
    chk(n inside {[600:720]}, 1'b1);
    chk({poweredUp, calKind}, 4'h8);
    repeat (1000) @(posedge ref_clk);
    // Every calibration variant by launch bit: kind and length
    for (int i = 0; i < 8; i++) begin
      wr(REG_CTRL, ROW_D[i]);
      wait_pulse(1'b0, 1000, n);
      chk(n inside {[ROW_N[i]*16-16:ROW_N[i]*16+24]}, 1'b1);
      chk(calKind, {ROW_D[i][5], ROW_D[i][4:3]});
      repeat (40) @(posedge ref_clk);
      chk(poweredUp, 1'b1);
    end
    // Software conversion needs a bare power-up write first
    wr(REG_CTRL, 8'h41);
    rd(REG_STAT);
    chk(stat[STAT_REFUSED], 1'b1);
    wr(REG_STAT, 8'h04);
    wr(REG_CTRL, 8'h01);
    wr(REG_CTRL, 8'h41);
    wait_pulse(1'b1, 1000, n);
    chk(n inside {[320:360]}, 1'b1);
    // Partial down between conversions: trigger wakes, conversion ends down
    repeat (40) @(posedge ref_clk);
    wr(REG_CTRL, 8'h03);
    repeat (10) @(posedge ref_clk);
    chk({poweredUp, partialDown}, 2'b01);
    wr(REG_PULSE, 8'h01);
    repeat (300) @(posedge ref_clk);
    chk(poweredUp, 1'b0);
    repeat (220) @(posedge ref_clk);
    chk(poweredUp, 1'b1);
    wait_pulse(1'b1, 1000, n);
    repeat (5) @(posedge ref_clk);
    chk(poweredUp, 1'b0);
    // Full down by write ignores the trigger; a power-up write wakes in 500
    wr(REG_CTRL, 8'h02);
    wr(REG_PULSE, 8'h01);
    repeat (700) @(posedge ref_clk);
    chk(poweredUp, 1'b0);
    wr(REG_CTRL, 8'h01);
    repeat (300) @(posedge ref_clk);
    chk(poweredUp, 1'b0);
    repeat (220) @(posedge ref_clk);
    chk(poweredUp, 1'b1);
    // Launch while partial down is pending is refused
    wr(REG_CTRL, 8'h03);
    wr(REG_CTRL, 8'h07);
    rd(REG_STAT);
    chk(stat[STAT_REFUSED], 1'b1);
    test_done();
  end
endmodule : testbench
`default_nettype wire
